// ---- hw/vcp_map.svh ----
/*
 Constants of the pin-strapped voice codec serial port: counts, field
 positions, reset values and bus offsets. Included by the package and the
 design modules; assumes nothing else.
*/
// What this block does
// - Mode pin low gives slave, high master.
// - Slot pin high enables time-slot operation.
// - Shift clock input in slave, output in master.
// - Frame strobe input in slave, output master.
// - Device emits 16-bit ADC words serially.
// - Slot mode drives serial out only in slot.
// - Chain output driven only in slot mode.
// - System clock pin output unless crystal grounded.
// - Bypass pin high skips DC-blocking filter.
// - Return pin high feeds ADC words to DAC.
// - Sleep pin low holds power-down.
// - Sleep pin rising starts reset initialization.
// - Undriven mode pins read as low.
// - Strobe at sample rate, clock sixteen times.
// - Sample input on rise, launch on fall.
// - Two's-complement words, most significant first.
// - Initialization 1024 cycles, serial out released.
`ifndef VCP_MAP_SVH
`define VCP_MAP_SVH

`define VCP_WORD_BITS 16
`define VCP_INIT_CYCLES 1024
`define VCP_SYS_PER_FRAME 512
`define VCP_SYS_PER_BCK 32
`define VCP_HPF_FRAC 8
`define VCP_HPF_SHIFT 6
`define VCP_SYNC_STAGES 2

`define VCP_OFS_ADC_SAMPLE 2'h0
`define VCP_OFS_DAC_SAMPLE 2'h1
`define VCP_OFS_STATUS 2'h2
`define VCP_OFS_FRAMES 2'h3

`define VCP_ST_MASTER 0
`define VCP_ST_TSLOT 1
`define VCP_ST_BYPASS 2
`define VCP_ST_LOOP 3
`define VCP_ST_DOWN 4
`define VCP_ST_INIT 5
`define VCP_ST_DAC_NEW 6
`define VCP_ST_XTAL_GND 7

`define VCP_ADC_RESET 16'h0000

`endif

// ---- hw/vcp_pkg.sv ----
/*
 Types of the voice codec serial port: power state, mode bundle and link
 bundle. Assumes vcp_map.svh for the counts.
*/
`include "vcp_map.svh"

package vcp_pkg;

    typedef enum logic [2:0] {
        VCP_DOWN = 3'b001,
        VCP_INIT = 3'b010,
        VCP_RUN  = 3'b100
    } vcp_pwr_e;

    typedef struct packed {
        logic xtal_gnd;
        logic sleep_n;
        logic loop;
        logic bypass;
        logic tslot;
        logic master;
    } vcp_mode_s;

    typedef struct packed {
        logic din;
        logic fs;
        logic shift_clock;
    } vcp_link_s;

    typedef logic [`VCP_WORD_BITS-1:0] vcp_word_t;

endpackage : vcp_pkg

// ---- hw/vcp_sync.sv ----
/*
 Two-stage synchroniser bank for pin inputs. Assumes the inputs are
 asynchronous to clock_i; outputs settle low under reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vcp_map.svh"

module vcp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,             // System clock
    input wire logic nrst_i,              // Async reset, active low
    input wire logic [WIDTH-1:0] async_i, // Pin levels
    output logic [WIDTH-1:0] sync_o       // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Reset low so that an undriven pin reads as its pull-down would
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : vcp_sync

`default_nettype wire

// ---- hw/vcp_top.sv ----
/*
 Serial port and mode control of a 16-bit mono voice codec, with an
 Avalon-MM slave for the sample words and status.
 Assumes clock_i is the system clock at 512 times the sample rate, that
 pins are resolved outside from the output enables, and that the far
 party's clocks are slow against clock_i (at least 8 cycles per phase).
*/
`timescale 1ns/1ps
`default_nettype none
`include "vcp_map.svh"

module vcp_top
    import vcp_pkg::*;
#(
    parameter int WORD_BITS = `VCP_WORD_BITS,
    parameter int INIT_CYCLES = `VCP_INIT_CYCLES,
    parameter int SYS_PER_FRAME = `VCP_SYS_PER_FRAME,
    parameter int SYS_PER_BCK = `VCP_SYS_PER_BCK
) (
    input wire logic clock_i,                  // System clock
    input wire logic nrst_i,                   // Async reset, active low
    input wire logic [3:0] avs_address_i,      // Byte address
    input wire logic avs_read_i,               // Read request
    input wire logic avs_write_i,              // Write request
    input wire logic [31:0] avs_writedata_i,   // Write data
    input wire logic [3:0] avs_byteenable_i,   // Byte lanes
    output logic [31:0] avs_readdata_o,        // Read data
    output logic avs_waitrequest_o,            // Stall, high until answer
    input wire logic master_slave_select_i,    // High selects master
    input wire logic time_slot_select_i,       // High enables slots
    input wire logic dc_block_bypass_i,        // High bypasses DC filter
    input wire logic adc_to_dac_return_i,      // High loops ADC to DAC
    input wire logic sleep_reset_n_i,          // Low powers down
    input wire logic crystal_in_grounded_i,    // High when crystal_in tied low
    input wire logic shift_clock_i,            // Shift clock pin level
    output logic shift_clock_o,                // Shift clock drive
    output logic shift_clock_oe_o,             // Shift clock enable
    input wire logic frame_strobe_i,           // Frame strobe pin level
    output logic frame_strobe_o,               // Frame strobe drive
    output logic frame_strobe_oe_o,            // Frame strobe enable
    input wire logic dac_serial_in_i,          // Serial DAC data
    output logic adc_serial_out_o,             // Serial ADC data
    output logic adc_serial_out_oe_o,          // Serial ADC enable
    output logic frame_strobe_chain_out_o,     // Chain strobe drive
    output logic frame_strobe_chain_out_oe_o,  // Chain strobe enable
    output logic system_clock_pin_o,           // System clock divided by two
    output logic system_clock_pin_oe_o,        // System clock pin enable
    output logic [WORD_BITS-1:0] dac_sample_o, // Word for the DAC
    output logic dac_sample_valid_o            // One-cycle new DAC word
);

    localparam int FRM_W = $clog2(SYS_PER_FRAME);
    localparam int INIT_W = $clog2(INIT_CYCLES + 1);
    localparam int BIT_W = $clog2(WORD_BITS + 1);
    localparam int HF = `VCP_HPF_FRAC;
    localparam int AW = WORD_BITS + HF;
    localparam int BCK_BIT = $clog2(SYS_PER_BCK) - 1;
    localparam logic [BIT_W-1:0] WORD_CNT = BIT_W'(WORD_BITS);
    localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

    generate
        if (WORD_BITS < 2 || WORD_BITS > 16) begin : g_bad_word
            $error("WORD_BITS must lie in 2..16");
        end
        if (SYS_PER_BCK < 4 || (SYS_PER_BCK & (SYS_PER_BCK - 1)) != 0) begin : g_bad_bck
            $error("SYS_PER_BCK must be a power of two, at least 4");
        end
        if (SYS_PER_FRAME != SYS_PER_BCK * WORD_BITS) begin : g_bad_frame
            $error("SYS_PER_FRAME must be SYS_PER_BCK times WORD_BITS");
        end
        if (INIT_CYCLES < 1 || INIT_CYCLES > 4096) begin : g_bad_init
            $error("INIT_CYCLES must lie in 1..4096");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [WORD_BITS-1:0] shl_in(input logic [WORD_BITS-1:0] sr,
                                                    input logic b);
        shl_in = {sr[WORD_BITS-2:0], b};
    endfunction : shl_in

    function automatic logic [WORD_BITS-1:0] sat_word(input logic [WORD_BITS:0] v);
        if (v[WORD_BITS] != v[WORD_BITS-1]) begin
            sat_word = {v[WORD_BITS], {(WORD_BITS-1){~v[WORD_BITS]}}};
        end else begin
            sat_word = v[WORD_BITS-1:0];
        end
    endfunction : sat_word

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    vcp_mode_s mode;
    vcp_link_s link;

    vcp_sync #(
        .WIDTH($bits(vcp_mode_s) + $bits(vcp_link_s))
    ) u_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .async_i({crystal_in_grounded_i, sleep_reset_n_i, adc_to_dac_return_i,
                  dc_block_bypass_i, time_slot_select_i, master_slave_select_i,
                  dac_serial_in_i, frame_strobe_i, shift_clock_i}),
        .sync_o({mode, link})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Power state: power-down, initialization, run

    vcp_pwr_e pwr_q, pwr_d;
    logic sleep_prev_q;
    logic [INIT_W-1:0] init_cnt_q;
    wire logic sleep_rise = mode.sleep_n & ~sleep_prev_q;
    wire logic run = (pwr_q == VCP_RUN);
    wire logic init_done = (init_cnt_q == INIT_LAST);

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            VCP_DOWN: begin
                if (sleep_rise) begin
                    pwr_d = VCP_INIT;
                end
            end
            VCP_INIT: begin
                if (!mode.sleep_n) begin
                    pwr_d = VCP_DOWN;
                end else if (init_done) begin
                    pwr_d = VCP_RUN;
                end
            end
            VCP_RUN: begin
                if (!mode.sleep_n) begin
                    pwr_d = VCP_DOWN;
                end
            end
            default: pwr_d = VCP_DOWN;
        endcase
    end

    // Power-on starts in initialization; a low sleep pin then wins at once
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_q <= VCP_INIT;
            sleep_prev_q <= 1'b0;
            init_cnt_q <= '0;
        end else begin
            pwr_q <= pwr_d;
            sleep_prev_q <= mode.sleep_n;
            init_cnt_q <= (pwr_q == VCP_INIT && !init_done) ? init_cnt_q + 1'b1 : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master clock divider

    logic [FRM_W-1:0] div_q;
    // Parked at all ones outside master mode, so a new master starts with whole pulses
    wire logic [FRM_W-1:0] div_nx = (run & mode.master) ? div_q + 1'b1 : '1;
    logic bck_gen_q, fs_gen_q;

    // Strobe changes only where the shift clock falls, one bit period wide
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= '0;
            bck_gen_q <= 1'b0;
            fs_gen_q <= 1'b0;
        end else begin
            div_q <= div_nx;
            bck_gen_q <= run & mode.master & div_nx[BCK_BIT];
            fs_gen_q <= run & mode.master & (div_nx[FRM_W-1:BCK_BIT+1] == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the active clock source

    logic bck_prev_q;
    wire logic bck_lvl = mode.master ? bck_gen_q : link.shift_clock;
    wire logic fs_lvl = mode.master ? fs_gen_q : link.fs;
    wire logic bck_rise = run & bck_lvl & ~bck_prev_q;
    wire logic bck_fall = run & ~bck_lvl & bck_prev_q;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bck_prev_q <= 1'b0;
        end else begin
            bck_prev_q <= bck_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ADC path: DC-blocking filter applied once per frame

    logic [WORD_BITS-1:0] adc_word_q;
    logic signed [AW-1:0] dc_est_q;
    wire logic signed [AW-1:0] x_ext = {adc_word_q, {HF{1'b0}}};
    wire logic signed [AW:0] dc_diff = {x_ext[AW-1], x_ext} - {dc_est_q[AW-1], dc_est_q};
    wire logic signed [AW:0] dc_step = dc_diff >>> `VCP_HPF_SHIFT;
    wire logic signed [AW-1:0] dc_est_nx = dc_est_q + dc_step[AW-1:0];
    wire logic [WORD_BITS:0] hpf_wide = {adc_word_q[WORD_BITS-1], adc_word_q}
                                      - {dc_est_q[AW-1], dc_est_q[AW-1:HF]};
    wire logic [WORD_BITS-1:0] adc_filt = mode.bypass ? adc_word_q : sat_word(hpf_wide);
    wire logic frame_start = bck_rise & fs_lvl;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dc_est_q <= '0;
        end else if (!run) begin
            dc_est_q <= '0;
        end else if (frame_start && !mode.bypass) begin
            dc_est_q <= dc_est_nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive: DAC words sampled on rising shift clock

    logic [BIT_W-1:0] rx_cnt_q;
    logic [WORD_BITS-1:0] rx_sr_q, loop_word_q, dac_q;
    logic dac_valid_q;
    wire logic [WORD_BITS-1:0] rx_nx = shl_in(rx_sr_q, link.din);
    wire logic rx_take = bck_rise & ~fs_lvl & (rx_cnt_q != '0);
    wire logic rx_last = rx_take & (rx_cnt_q == BIT_W'(1));

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_cnt_q <= '0;
            rx_sr_q <= '0;
            loop_word_q <= '0;
            dac_q <= '0;
            dac_valid_q <= 1'b0;
        end else begin
            dac_valid_q <= rx_last;
            if (!run) begin
                rx_cnt_q <= '0;
            end else if (frame_start) begin
                rx_cnt_q <= WORD_CNT;
                loop_word_q <= adc_filt;
            end else if (rx_take) begin
                rx_sr_q <= rx_nx;
                rx_cnt_q <= rx_cnt_q - 1'b1;
            end
            if (rx_last) begin
                dac_q <= mode.loop ? loop_word_q : rx_nx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit: ADC words launched on falling shift clock

    logic tx_arm_q, tx_busy_q, dout_q, dout_oe_q, fso_q;
    logic [BIT_W-1:0] tx_cnt_q;
    logic [WORD_BITS-1:0] tx_sr_q;
    wire logic tx_end = bck_fall & tx_busy_q & ~tx_arm_q & (tx_cnt_q == '0);
    wire logic tx_busy_nx = tx_busy_q ? ~tx_end : (bck_fall & tx_arm_q);
    // In slot mode only the own slot is driven, otherwise all of run; released outside run
    wire logic dout_oe_nx = run & (~mode.tslot | tx_busy_nx | (tx_arm_q & bck_fall));

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_arm_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_cnt_q <= '0;
            tx_sr_q <= '0;
            dout_q <= 1'b0;
            fso_q <= 1'b0;
        end else if (!run) begin
            tx_arm_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_cnt_q <= '0;
            dout_q <= 1'b0;
            fso_q <= 1'b0;
        end else begin
            if (frame_start) begin
                tx_arm_q <= 1'b1;
                tx_sr_q <= adc_filt;
            end else if (bck_fall && tx_arm_q) begin
                tx_arm_q <= 1'b0;
                tx_busy_q <= 1'b1;
                dout_q <= tx_sr_q[WORD_BITS-1];
                tx_sr_q <= shl_in(tx_sr_q, 1'b0);
                tx_cnt_q <= WORD_CNT - 1'b1;
            end else if (bck_fall && tx_busy_q && tx_cnt_q != '0) begin
                dout_q <= tx_sr_q[WORD_BITS-1];
                tx_sr_q <= shl_in(tx_sr_q, 1'b0);
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end else if (tx_end) begin
                tx_busy_q <= 1'b0;
                dout_q <= 1'b0;
                fso_q <= mode.tslot;
            end else if (bck_fall) begin
                fso_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    logic sck_q;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dout_oe_q <= 1'b0;
            sck_q <= 1'b0;
            shift_clock_oe_o <= 1'b0;
            frame_strobe_oe_o <= 1'b0;
            frame_strobe_chain_out_oe_o <= 1'b0;
            system_clock_pin_oe_o <= 1'b0;
        end else begin
            dout_oe_q <= dout_oe_nx;
            sck_q <= ~sck_q;
            shift_clock_oe_o <= mode.master;
            frame_strobe_oe_o <= mode.master;
            frame_strobe_chain_out_oe_o <= mode.tslot;
            system_clock_pin_oe_o <= ~mode.xtal_gnd;
        end
    end

    assign shift_clock_o = bck_gen_q;
    assign frame_strobe_o = fs_gen_q;
    assign adc_serial_out_o = dout_q;
    assign adc_serial_out_oe_o = dout_oe_q;
    assign frame_strobe_chain_out_o = fso_q;
    assign system_clock_pin_o = sck_q;
    assign dac_sample_o = dac_q;
    assign dac_sample_valid_o = dac_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then the answer

    logic wait_q, dac_new_q;
    logic [31:0] rdata_q;
    logic [15:0] frames_q;
    wire logic req = avs_read_i | avs_write_i;
    wire logic accept = req & ~wait_q;
    wire logic aligned = (avs_address_i[1:0] == 2'h0);
    wire logic [1:0] reg_sel = avs_address_i[3:2];
    wire logic wr_adc = accept & avs_write_i & aligned & (reg_sel == `VCP_OFS_ADC_SAMPLE);
    wire logic rd_dac = accept & avs_read_i & aligned & (reg_sel == `VCP_OFS_DAC_SAMPLE);
    wire logic [7:0] status = {mode.xtal_gnd, dac_new_q, (pwr_q == VCP_INIT),
                               (pwr_q == VCP_DOWN), mode.loop, mode.bypass,
                               mode.tslot, mode.master};
    wire logic [31:0] rd_mux =
        !aligned ? 32'h0000_0000 :
        (reg_sel == `VCP_OFS_ADC_SAMPLE) ? {{(32-WORD_BITS){1'b0}}, adc_word_q} :
        (reg_sel == `VCP_OFS_DAC_SAMPLE) ? {{(32-WORD_BITS){1'b0}}, dac_q} :
        (reg_sel == `VCP_OFS_STATUS) ? {24'h00_0000, status} :
        {16'h0000, frames_q};

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            adc_word_q <= `VCP_ADC_RESET;
            dac_new_q <= 1'b0;
            frames_q <= 16'h0000;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req && wait_q) begin
                rdata_q <= avs_read_i ? rd_mux : 32'h0000_0000;
            end
            if (wr_adc) begin
                adc_word_q <= {avs_byteenable_i[1] ? avs_writedata_i[15:8] : adc_word_q[15:8],
                               avs_byteenable_i[0] ? avs_writedata_i[7:0] : adc_word_q[7:0]};
            end
            // A word landing in the same cycle as the clearing read wins
            dac_new_q <= rx_last | (dac_new_q & ~rd_dac);
            frames_q <= frame_start ? frames_q + 16'h0001 : frames_q;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

endmodule : vcp_top

`default_nettype wire

// ---- bench/vcp_properties.sv ----
/*
 Checker of the vcp_top pins and bus handshake, bound to every vcp_top.
 Assumes mode pins are held for several cycles and master timing is default.
*/
`timescale 1ns/1ps
`default_nettype none
module vcp_properties (
    input wire logic clock_i, // System clock
    input wire logic nrst_i, // Reset
    input wire logic avs_read_i, // Read
    input wire logic avs_write_i, // Write
    input wire logic avs_waitrequest_o, // Stall
    input wire logic master_slave_select_i, // Mode
    input wire logic time_slot_select_i, // Slots
    input wire logic sleep_reset_n_i, // Sleep
    input wire logic crystal_in_grounded_i, // Crystal
    input wire logic shift_clock_o, // Bit clock
    input wire logic shift_clock_oe_o, // Bit clock enable
    input wire logic frame_strobe_o, // Strobe
    input wire logic frame_strobe_oe_o, // Strobe enable
    input wire logic adc_serial_out_oe_o, // Data enable
    input wire logic frame_strobe_chain_out_oe_o, // Chain enable
    input wire logic system_clock_pin_oe_o, // Clock pin enable
    input wire logic dac_sample_valid_o // New word
);
default clocking @(posedge clock_i); endclocking
default disable iff (!nrst_i);
////////////////////////////////////////////////////////////////////////////////
bck_master_a: assert property (master_slave_select_i [*5] |-> shift_clock_oe_o)
    else $error("bit clock not driven in master mode");
fs_slave_a: assert property (!master_slave_select_i [*5] |-> !frame_strobe_oe_o)
    else $error("strobe driven in slave mode");
chain_off_a: assert property (!time_slot_select_i [*5] |-> !frame_strobe_chain_out_oe_o)
    else $error("chain strobe driven outside slot mode");
xtal_gnd_a: assert property (crystal_in_grounded_i [*5] |-> !system_clock_pin_oe_o)
    else $error("clock pin driven with crystal input grounded");
sleep_hiz_a: assert property (!sleep_reset_n_i [*5] |-> !adc_serial_out_oe_o)
    else $error("serial out driven in power-down");
init_hiz_a: assert property ($rose(sleep_reset_n_i) |-> ##3 !adc_serial_out_oe_o [*8])
    else $error("serial out driven during initialisation");
bck_half_a: assert property ($rose(shift_clock_o) |-> ##16 $fell(shift_clock_o))
    else $error("master bit clock high phase not 16 cycles");
fs_width_a: assert property ($rose(frame_strobe_o) |-> ##32 $fell(frame_strobe_o))
    else $error("master strobe not one bit period wide");
bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus request not answered next cycle");
bus_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
cover property (dac_sample_valid_o);
cover property ($rose(frame_strobe_o));
cover property (frame_strobe_chain_out_oe_o ##1 !frame_strobe_chain_out_oe_o);
endmodule : vcp_properties
bind vcp_top vcp_properties vcp_properties_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .master_slave_select_i(master_slave_select_i), .time_slot_select_i(time_slot_select_i),
    .sleep_reset_n_i(sleep_reset_n_i), .crystal_in_grounded_i(crystal_in_grounded_i),
    .shift_clock_o(shift_clock_o), .shift_clock_oe_o(shift_clock_oe_o),
    .frame_strobe_o(frame_strobe_o), .frame_strobe_oe_o(frame_strobe_oe_o),
    .adc_serial_out_oe_o(adc_serial_out_oe_o), .dac_sample_valid_o(dac_sample_valid_o),
    .frame_strobe_chain_out_oe_o(frame_strobe_chain_out_oe_o),
    .system_clock_pin_oe_o(system_clock_pin_oe_o));
`default_nettype wire

// ---- bench/vcp_far_model.sv ----
/*
 Far-side serial port for a device in slave mode: makes bit clock and strobe, sends one
 word per frame and captures the returned word. Assumes a 160 ns bit clock.
*/
`timescale 1ns/1ps
`default_nettype none
module vcp_far_model (
    input wire logic en_i, // Run frames
    input wire logic [15:0] tx_i, // Word to send
    input wire logic dout_i, // Device serial out
    output logic bck_o, // Bit clock
    output logic fs_o, // Strobe
    output logic din_o, // Serial data
    output logic [15:0] rx_o // Captured word
);
int bit_n;
initial begin
    bck_o = 1'b0;
    fs_o = 1'b0;
    din_o = 1'b0;
    rx_o = 16'h0000;
end
// Seventeen bit periods: the strobe period carries no data; clock stands still between frames
always begin
    wait (en_i);
    #3.3;
    for (bit_n = 0; bit_n < 17; bit_n++) begin
        fs_o = (bit_n == 0);
        din_o = (bit_n != 0) ? tx_i[16 - bit_n] : ~din_o;
        #80 bck_o = 1'b1;
        if (bit_n != 0) rx_o = {rx_o[14:0], dout_i};
        #80 bck_o = 1'b0;
    end
end
endmodule : vcp_far_model
`default_nettype wire

// ---- bench/testbench.sv ----
/*
 Self-checking bench of vcp_top with the far-side model in slave mode.
 Assumes a short initialisation count to keep the run brief.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
import vcp_pkg::*;
logic clock_i = 1'b0;
logic nrst_i = 1'b0;
logic [3:0] adr = 4'h0;
logic rd = 1'b0;
logic wr = 1'b0;
logic [31:0] wd = 32'h0;
logic [31:0] rdata, q;
logic wt, sck_o, sck_oe, fs_o, fs_oe, dout, dout_oe, ch, ch_oe, sc, sc_oe, dv, en = 1'b0;
logic fbck, ffs, fdin, psck;
logic [15:0] dac, rx, tx = 16'h0000;
vcp_mode_s mode = 6'b010100;
int n_mismatch = 0;
int checks_done = 0;
int n, c, r;
wire sck_pin = sck_oe ? sck_o : fbck;
wire fs_pin = fs_oe ? fs_o : ffs;
wire dout_pin = dout_oe ? dout : ~dout;
always #2.5 clock_i = ~clock_i;
vcp_top #(.INIT_CYCLES(16)) vcp_top_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
    .master_slave_select_i(mode.master), .time_slot_select_i(mode.tslot),
    .dc_block_bypass_i(mode.bypass), .adc_to_dac_return_i(mode.loop),
    .sleep_reset_n_i(mode.sleep_n), .crystal_in_grounded_i(mode.xtal_gnd),
    .shift_clock_i(sck_pin), .shift_clock_o(sck_o), .shift_clock_oe_o(sck_oe),
    .frame_strobe_i(fs_pin), .frame_strobe_o(fs_o), .frame_strobe_oe_o(fs_oe),
    .dac_serial_in_i(fdin), .adc_serial_out_o(dout), .adc_serial_out_oe_o(dout_oe),
    .frame_strobe_chain_out_o(ch), .frame_strobe_chain_out_oe_o(ch_oe),
    .system_clock_pin_o(sc), .system_clock_pin_oe_o(sc_oe), .dac_sample_o(dac),
    .dac_sample_valid_o(dv));
vcp_far_model vcp_far_model_i (.en_i(en), .tx_i(tx), .dout_i(dout_pin), .bck_o(fbck),
    .fs_o(ffs), .din_o(fdin), .rx_o(rx));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        n_mismatch++;
        $display("ERROR %0t ns: value %h expected %h", $time, got, exp);
    end
endtask : chk
task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
endtask : cyc
task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
        @(posedge clock_i);
        k++;
    end while (wt !== 1'b0 && k < 100);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(k < 100, 1);
    cyc(1);
endtask : bus
// One far-side frame; returns once the released tail of the frame has passed
task automatic frame(input logic [15:0] w, input logic [15:0] e);
    int k;
    k = 0;
    tx <= w;
    en <= 1'b1;
    do begin
        @(posedge clock_i);
        k++;
    end while (dv !== 1'b1 && k < 2000);
    en <= 1'b0;
    chk(k < 2000, 1);
    chk(dac, e);
    cyc(60);
endtask : frame
task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask : end_sim
////////////////////////////////////////////////////////////////////////////////
task automatic t_regs;
    bus(1, 4'h0, 32'h8001);
    bus(0, 4'h0, 0);
    chk(q, 32'h8001);
    bus(1, 4'h8, 32'hFF);
    bus(0, 4'h8, 0);
    chk(q & 32'hBF, 32'h04);
    bus(0, 4'h2, 0);
    chk(q, 0);
    $display("done registers");
endtask : t_regs
task automatic t_slave;
    mode.tslot <= 1'b1;
    cyc(5);
    chk(ch_oe, 1);
    frame(16'hA5C3, 16'hA5C3);
    chk(rx, 16'h8001);
    chk(dout_oe, 0);
    chk(ch, 1);
    chk({sck_oe, fs_oe}, 0);
    mode.tslot <= 1'b0;
    cyc(5);
    chk(ch_oe, 0);
    mode.loop <= 1'b1;
    cyc(5);
    frame(16'h1234, 16'h8001);
    mode.loop <= 1'b0;
    mode.bypass <= 1'b0;
    frame(16'h0F0F, 16'h0F0F);
    frame(16'hF0F0, 16'hF0F0);
    chk(rx !== 16'h8001, 1);
    $display("done slave");
endtask : t_slave
task automatic t_master;
    mode.master <= 1'b1;
    cyc(5);
    chk({sck_oe, fs_oe}, 2'b11);
    n = 0;
    while (fs_o !== 1'b1 && n < 2000) begin
        cyc(1);
        n++;
    end
    while (fs_o !== 1'b0 && n < 2000) begin
        cyc(1);
        n++;
    end
    c = 0;
    r = 0;
    psck = sck_o;
    while (fs_o !== 1'b1 && c < 2000) begin
        cyc(1);
        c++;
        r += (sck_o === 1'b1 && psck === 1'b0);
        psck = sck_o;
    end
    chk(c, 480);
    chk(r, 15);
    while (fs_o !== 1'b0 && n < 4000) begin
        cyc(1);
        n++;
    end
    mode.master <= 1'b0;
    cyc(5);
    $display("done master");
endtask : t_master
task automatic t_power;
    mode.sleep_n <= 1'b0;
    cyc(10);
    bus(0, 4'h8, 0);
    chk(q[5:4], 2'b01);
    chk(dout_oe, 0);
    mode.sleep_n <= 1'b1;
    cyc(5);
    bus(0, 4'h8, 0);
    chk(q[5:4], 2'b10);
    cyc(30);
    bus(0, 4'h8, 0);
    chk(q[5:4], 2'b00);
    mode.xtal_gnd <= 1'b1;
    cyc(5);
    chk(sc_oe, 0);
    mode.xtal_gnd <= 1'b0;
    cyc(5);
    chk(sc_oe, 1);
    psck = sc;
    cyc(1);
    chk(sc, !psck);
    $display("done power");
endtask : t_power
initial begin
    cyc(10);
    nrst_i <= 1'b1;
    cyc(40);
    t_regs();
    t_slave();
    t_master();
    t_power();
    end_sim();
end
initial begin
    #300000;
    n_mismatch++;
    end_sim();
end
endmodule : testbench
`default_nettype wire
